//--- design/bit_sync.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

//--- design/twowire_map.svh
// Constants for the two-wire target port
`ifndef TWOWIRE_MAP_SVH
`define TWOWIRE_MAP_SVH
`define ADDR_FIXED_HI 4'h9
`define GC_ADDR 7'h00
`define ARA_BYTE 8'h19
`define HS_CODE_TOP 5'h01
`define GC_RELATCH 8'h04
`define GC_RESET 8'h06
`define PTR_RESET 8'h00
`define BIT_CNT_FULL 4'h8
`define BIT_CNT_ONE 4'h1
`define TOUT_US 54000
`define REF_CLK_MHZ 200
`define TOUT_CNT_W 24
`endif

//--- design/twowire_pkg.sv
// Types shared by the two-wire target port
package twowire_pkg;
  typedef enum logic [2:0] {
    LS_IDLE,
    LS_RECV,
    LS_ACK,
    LS_SEND,
    LS_MACK
  } link_state_t;
  typedef enum logic [1:0] {
    PH_ADDR,
    PH_PTR,
    PH_DATA,
    PH_GCMD
  } phase_t;
  typedef enum logic [2:0] {
    EV_PTR,
    EV_WR,
    EV_RD,
    EV_ARA_WON,
    EV_GC_RESET
  } ev_kind_t;
endpackage

//--- design/twowire_target.sv
// Two-wire / SMBus target port of a temperature sensor
// Summary of operation
// - Answer address 1001 plus three address-select pin levels.
// - Address-select pins latched at each start, not tracked.
// - First byte after write address loads the register pointer.
// - Reads use last written pointer; pointer kept across transactions.
// - Pointer-only write accepted; read follows via repeated start.
// - Register words move high byte first, then low byte.
// - Receiver acks address, pointer and data; data written to register.
// - Transmitter sends high then low byte; controller nack ends it.
// - With alert active, ack alert response and return own address.
// - Eighth reply bit: one above upper limit, zero below lower.
// - Arbitrate on reply; winner clears alert, loser keeps it.
// - Ack general call address with write bit; next byte is command.
// - Command 04 relatches address pins; 06 resets registers.
// - Hs controller code is not acked but enables Hs-mode.
// - Hs-mode held across repeated starts, dropped on stop.
// - Line low 54 ms inside a transaction resets and releases.
// - In latched alert mode any register read clears alert.
// - General call reset clears alert, fault counter, latch mode.
`timescale 1ns/10ps
`include "twowire_map.svh"
module twowire_target
  import twowire_pkg::*;
#(
  parameter int unsigned TOUT_CYCLES = `TOUT_US * `REF_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_select_bit2,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit0,
  input wire logic [15:0] reg_rd_data,
  input wire logic alert_active,
  input wire logic alert_above,
  input wire logic alert_latch_mode_bit,
  output logic [7:0] reg_ptr,
  output logic reg_wr_stb,
  output logic reg_wr_hi,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_stb,
  output logic alert_clear,
  output logic soft_reset,
  output logic hs_mode
);
  // ---------------- Link domain (bus_clk) ----------------
  logic link_rst;
  logic [8:0] lsync;
  link_state_t state_ff;
  phase_t phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [2:0] own_lo_ff;
  logic relatch_ff;
  logic send_ff;
  logic ara_ff;
  logic hi_next_ff;
  logic mack_ok_ff;
  logic busy_ff;
  logic hs_ff;
  logic sda_oe_n_ff;
  logic sda_out_ff;
  logic ev_tgl_ff;
  ev_kind_t ev_kind_ff;
  logic [7:0] ev_data_ff;
  logic ev_hi_ff;
  logic ack_prev_ff;
  logic [15:0] rd_hold_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  // Core-domain registers read across the crossing
  logic rd_ack_tgl_ff;
  logic [15:0] rd_word_ff;
  logic tout_ff;

  bit_sync #(.WIDTH(1)) u_rst_sync (
    .clk(bus_clk),
    .rst(1'b0),
    .d(rst),
    .q(link_rst)
  );

  bit_sync #(.WIDTH(9)) u_link_sync (
    .clk(bus_clk),
    .rst(1'b0),
    .d({scl_in, sda_in, addr_select_bit2, addr_select_bit1,
        addr_select_bit0, alert_active, alert_above, rd_ack_tgl_ff,
        tout_ff}),
    .q(lsync)
  );

  wire scl_l = lsync[8];
  wire sda_l = lsync[7];
  wire [2:0] pins_l = lsync[6:4];
  wire alert_act_l = lsync[3];
  wire alert_above_l = lsync[2];
  wire ack_tgl_l = lsync[1];
  wire tout_l = lsync[0];

  wire scl_rise = scl_l & ~scl_prev_ff;
  wire scl_fall = ~scl_l & scl_prev_ff;
  wire start_det = scl_l & scl_prev_ff & sda_prev_ff & ~sda_l;
  wire stop_det = scl_l & scl_prev_ff & ~sda_prev_ff & sda_l;
  wire byte_done = bit_cnt_ff == `BIT_CNT_FULL;

  wire [6:0] own_addr = {`ADDR_FIXED_HI, own_lo_ff};
  wire is_own = shift_ff[7:1] == own_addr;
  wire is_gc = (shift_ff[7:1] == `GC_ADDR) & ~shift_ff[0];
  wire is_ara = (shift_ff == `ARA_BYTE) & alert_act_l;
  wire is_hs = shift_ff[7:3] == `HS_CODE_TOP;
  wire addr_ack = is_own | is_gc | is_ara;
  wire gc_relatch = shift_ff == `GC_RELATCH;
  wire gc_reset = shift_ff == `GC_RESET;
  wire [7:0] ara_byte = {own_addr, alert_above_l};
  wire [7:0] rd_byte = hi_next_ff ? rd_hold_ff[15:8] : rd_hold_ff[7:0];
  wire [7:0] tx_byte = ara_ff ? ara_byte : rd_byte;
  wire arb_lost = ara_ff & sda_oe_n_ff & ~sda_l;
  wire ack_edge = ack_tgl_l ^ ack_prev_ff;

  always_ff @(posedge bus_clk) begin
    if (link_rst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      ack_prev_ff <= 1'b0;
      rd_hold_ff <= 16'h0000;
    end else begin
      scl_prev_ff <= scl_l;
      sda_prev_ff <= sda_l;
      ack_prev_ff <= ack_tgl_l;
      if (ack_edge) begin
        rd_hold_ff <= rd_word_ff;
      end
    end
  end

  always_ff @(posedge bus_clk) begin
    if (link_rst) begin
      state_ff <= LS_IDLE;
      phase_ff <= PH_ADDR;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      own_lo_ff <= 3'h0;
      relatch_ff <= 1'b1;
      send_ff <= 1'b0;
      ara_ff <= 1'b0;
      hi_next_ff <= 1'b1;
      mack_ok_ff <= 1'b0;
      busy_ff <= 1'b0;
      hs_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      sda_out_ff <= 1'b0;
      ev_tgl_ff <= 1'b0;
      ev_kind_ff <= EV_PTR;
      ev_data_ff <= 8'h00;
      ev_hi_ff <= 1'b0;
    end else if (tout_l) begin
      state_ff <= LS_IDLE;
      busy_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      ara_ff <= 1'b0;
    end else if (relatch_ff) begin
      own_lo_ff <= pins_l;
      relatch_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= LS_IDLE;
      busy_ff <= 1'b0;
      hs_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      ara_ff <= 1'b0;
    end else if (start_det) begin
      own_lo_ff <= pins_l;
      state_ff <= LS_RECV;
      phase_ff <= PH_ADDR;
      bit_cnt_ff <= 4'h0;
      busy_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      ara_ff <= 1'b0;
      send_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        LS_IDLE: begin
          sda_oe_n_ff <= 1'b1;
        end
        LS_RECV: begin
          if (scl_rise && !byte_done) begin
            shift_ff <= {shift_ff[6:0], sda_l};
            bit_cnt_ff <= bit_cnt_ff + `BIT_CNT_ONE;
          end else if (scl_fall && byte_done) begin
            unique case (phase_ff)
              PH_ADDR: begin
                if (addr_ack) begin
                  sda_oe_n_ff <= 1'b0;
                  state_ff <= LS_ACK;
                  send_ff <= shift_ff[0];
                  ara_ff <= is_ara;
                  hi_next_ff <= 1'b1;
                  phase_ff <= is_gc ? PH_GCMD : PH_PTR;
                  if (is_own && shift_ff[0]) begin
                    ev_tgl_ff <= ~ev_tgl_ff;
                    ev_kind_ff <= EV_RD;
                  end
                end else begin
                  if (is_hs) begin
                    hs_ff <= 1'b1;
                  end
                  state_ff <= LS_IDLE;
                end
              end
              PH_PTR: begin
                sda_oe_n_ff <= 1'b0;
                state_ff <= LS_ACK;
                phase_ff <= PH_DATA;
                ev_tgl_ff <= ~ev_tgl_ff;
                ev_kind_ff <= EV_PTR;
                ev_data_ff <= shift_ff;
              end
              PH_DATA: begin
                sda_oe_n_ff <= 1'b0;
                state_ff <= LS_ACK;
                hi_next_ff <= ~hi_next_ff;
                ev_tgl_ff <= ~ev_tgl_ff;
                ev_kind_ff <= EV_WR;
                ev_data_ff <= shift_ff;
                ev_hi_ff <= hi_next_ff;
              end
              PH_GCMD: begin
                sda_oe_n_ff <= 1'b0;
                state_ff <= LS_ACK;
                if (gc_relatch) begin
                  relatch_ff <= 1'b1;
                end
                if (gc_reset) begin
                  ev_tgl_ff <= ~ev_tgl_ff;
                  ev_kind_ff <= EV_GC_RESET;
                end
              end
            endcase
          end
        end
        LS_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= send_ff ? `BIT_CNT_ONE : 4'h0;
            shift_ff <= tx_byte;
            sda_oe_n_ff <= send_ff ? tx_byte[7] : 1'b1;
            state_ff <= send_ff ? LS_SEND : LS_RECV;
          end
        end
        LS_SEND: begin
          if (scl_rise && arb_lost) begin
            state_ff <= LS_IDLE;
            sda_oe_n_ff <= 1'b1;
            ara_ff <= 1'b0;
          end else if (scl_fall && byte_done) begin
            sda_oe_n_ff <= 1'b1;
            state_ff <= LS_MACK;
            mack_ok_ff <= 1'b0;
            hi_next_ff <= ~hi_next_ff;
            if (ara_ff) begin
              ev_tgl_ff <= ~ev_tgl_ff;
              ev_kind_ff <= EV_ARA_WON;
            end
          end else if (scl_fall) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            sda_oe_n_ff <= shift_ff[6];
            bit_cnt_ff <= bit_cnt_ff + `BIT_CNT_ONE;
          end
        end
        LS_MACK: begin
          if (scl_rise) begin
            mack_ok_ff <= ~sda_l & ~ara_ff;
            if (sda_l || ara_ff) begin
              state_ff <= LS_IDLE;
              ara_ff <= 1'b0;
            end
          end else if (scl_fall && mack_ok_ff) begin
            shift_ff <= tx_byte;
            sda_oe_n_ff <= tx_byte[7];
            bit_cnt_ff <= `BIT_CNT_ONE;
            state_ff <= LS_SEND;
          end
        end
        default: begin
          state_ff <= LS_IDLE;
        end
      endcase
    end
  end

  assign sda_out = sda_out_ff;
  assign sda_oe_n = sda_oe_n_ff;

  // ---------------- Core domain (ref_clk) ----------------
  logic [4:0] csync;
  logic ev_prev_ff;
  logic [7:0] reg_ptr_ff;
  logic reg_wr_stb_ff;
  logic reg_wr_hi_ff;
  logic [7:0] reg_wr_data_ff;
  logic reg_rd_stb_ff;
  logic alert_clear_ff;
  logic soft_reset_ff;
  logic hs_mode_ff;
  logic rd_pend_ff;
  logic [`TOUT_CNT_W-1:0] tout_cnt_ff;

  bit_sync #(.WIDTH(5)) u_core_sync (
    .clk(ref_clk),
    .rst(1'b0),
    .d({scl_in, sda_in, busy_ff, ev_tgl_ff, hs_ff}),
    .q(csync)
  );

  wire line_low_c = ~csync[4] | ~csync[3];
  wire busy_c = csync[2];
  wire ev_seen = csync[1] ^ ev_prev_ff;
  wire ev_ptr = ev_seen & (ev_kind_ff == EV_PTR);
  wire ev_wr = ev_seen & (ev_kind_ff == EV_WR);
  wire ev_rd = ev_seen & (ev_kind_ff == EV_RD);
  wire ev_won = ev_seen & (ev_kind_ff == EV_ARA_WON);
  wire ev_gcr = ev_seen & (ev_kind_ff == EV_GC_RESET);
  wire tout_hit = tout_cnt_ff == `TOUT_CNT_W'(TOUT_CYCLES - 1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ev_prev_ff <= 1'b0;
      reg_ptr_ff <= `PTR_RESET;
      reg_wr_stb_ff <= 1'b0;
      reg_wr_hi_ff <= 1'b0;
      reg_wr_data_ff <= 8'h00;
      reg_rd_stb_ff <= 1'b0;
      alert_clear_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
      hs_mode_ff <= 1'b0;
    end else begin
      ev_prev_ff <= csync[1];
      hs_mode_ff <= csync[0];
      reg_wr_stb_ff <= ev_wr;
      reg_rd_stb_ff <= ev_rd;
      soft_reset_ff <= ev_gcr;
      alert_clear_ff <= ev_won | (ev_rd & alert_latch_mode_bit);
      if (ev_wr) begin
        reg_wr_hi_ff <= ev_hi_ff;
        reg_wr_data_ff <= ev_data_ff;
      end
      if (ev_ptr) begin
        reg_ptr_ff <= ev_data_ff;
      end else if (ev_gcr) begin
        reg_ptr_ff <= `PTR_RESET;
      end
    end
  end

  // Read word captured one cycle after the strobe so the pointer settles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_pend_ff <= 1'b0;
      rd_word_ff <= 16'h0000;
      rd_ack_tgl_ff <= 1'b0;
    end else begin
      rd_pend_ff <= ev_rd;
      if (rd_pend_ff) begin
        rd_word_ff <= reg_rd_data;
        rd_ack_tgl_ff <= ~rd_ack_tgl_ff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tout_cnt_ff <= '0;
      tout_ff <= 1'b0;
    end else if (!busy_c) begin
      tout_cnt_ff <= '0;
      tout_ff <= 1'b0;
    end else if (!line_low_c || tout_ff) begin
      tout_cnt_ff <= '0;
    end else if (tout_hit) begin
      tout_ff <= 1'b1;
    end else begin
      tout_cnt_ff <= tout_cnt_ff + 1'b1;
    end
  end

  assign reg_ptr = reg_ptr_ff;
  assign reg_wr_stb = reg_wr_stb_ff;
  assign reg_wr_hi = reg_wr_hi_ff;
  assign reg_wr_data = reg_wr_data_ff;
  assign reg_rd_stb = reg_rd_stb_ff;
  assign alert_clear = alert_clear_ff;
  assign soft_reset = soft_reset_ff;
  assign hs_mode = hs_mode_ff;
endmodule

//--- verif/bus_ctrl_model.sv
// Behavioural two-wire bus controller with open-drain SDA
`timescale 1ns/10ps
module bus_ctrl_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // SCL half period in clk cycles, far above 1 kHz
  localparam int HALF = 30;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Start or repeated start, SCL left low
  task automatic start();
    hold(5);
    sda_drv = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_drv = 1'b0;
    hold(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    hold(5);
    sda_drv = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_drv = 1'b1;
  endtask
  // Shift nb bits of tx from the top, sampling the wire with SCL high
  task automatic xfer(input logic [8:0] tx, input int nb,
                      output logic [8:0] rx);
    rx = 9'h1ff;
    for (int i = 8; i > 8 - nb; i--) begin
      hold(5);
      sda_drv = tx[i];
      hold(HALF - 5);
      scl = 1'b1;
      hold(HALF);
      rx[i] = sda;
      scl = 1'b0;
    end
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the two-wire target port
`timescale 1ns/10ps
module tb;
  import twowire_pkg::*;
  localparam int TOUT = 2000;
  logic ref_clk = 1'b0;
  logic bus_clk = 1'b0;
  logic rst;
  logic [2:0] pins;
  logic [15:0] reg_rd_data;
  logic alert_active;
  logic alert_above;
  logic alert_latch_mode_bit;
  logic sda, scl, sda_drv, sda_out, sda_oe_n, ack;
  logic [7:0] reg_ptr, reg_wr_data, p;
  logic reg_wr_stb, reg_wr_hi, reg_rd_stb, alert_clear, soft_reset, hs_mode;
  logic [15:0] regs [256];
  logic [15:0] w, d;
  logic [8:0] rx;
  logic [8:0] wrq [$];
  logic [31:0] seed = 32'hb6a5aefc;
  int fail_count = 0;
  int checked = 0;
  int n_rd = 0;
  int n_clr = 0;
  int n_srst = 0;
  int e_rd, e_clr;
  always #2.5 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #7.5 bus_clk = ~bus_clk;
  end
  // Open-drain wire with pull-up
  assign sda = sda_drv & (sda_oe_n | sda_out);
  bus_ctrl_model ctrl_u (.clk(ref_clk), .sda(sda), .scl(scl),
    .sda_drv(sda_drv));
  twowire_target #(.TOUT_CYCLES(TOUT)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .bus_clk(bus_clk), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_bit2(pins[2]), .addr_select_bit1(pins[1]),
    .addr_select_bit0(pins[0]), .reg_rd_data(reg_rd_data),
    .alert_active(alert_active), .alert_above(alert_above),
    .alert_latch_mode_bit(alert_latch_mode_bit), .reg_ptr(reg_ptr),
    .reg_wr_stb(reg_wr_stb), .reg_wr_hi(reg_wr_hi),
    .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb),
    .alert_clear(alert_clear), .soft_reset(soft_reset), .hs_mode(hs_mode));
  // Register file side: answers within one cycle, logs strobes
  always @(negedge ref_clk) reg_rd_data <= regs[reg_ptr];
  always @(posedge ref_clk) begin
    if (reg_wr_stb === 1'b1) wrq.push_back({reg_wr_hi, reg_wr_data});
    n_rd += int'(reg_rd_stb === 1'b1);
    n_clr += int'(alert_clear === 1'b1);
    n_srst += int'(soft_reset === 1'b1);
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic snd(input logic [7:0] b);
    ctrl_u.xfer({b, 1'b1}, 9, rx);
    ack = !rx[0];
  endtask
  task automatic wr(input logic [7:0] ptr, input int nd,
                    input logic [15:0] dw);
    ctrl_u.start();
    snd({4'h9, pins, 1'b0});
    chk(ack, 1'b1);
    snd(ptr);
    chk(ack, 1'b1);
    for (int i = 0; i < nd; i++) begin
      snd(i == 0 ? dw[15:8] : dw[7:0]);
      chk(ack, 1'b1);
    end
  endtask
  task automatic rd(output logic [15:0] rw);
    ctrl_u.start();
    snd({4'h9, pins, 1'b1});
    chk(ack, 1'b1);
    ctrl_u.xfer(9'h1fe, 9, rx);
    rw[15:8] = rx[8:1];
    ctrl_u.xfer(9'h1ff, 9, rx);
    rw[7:0] = rx[8:1];
    ctrl_u.stop();
    ctrl_u.hold(20);
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    pins = 3'h0;
    alert_active = 1'b0;
    alert_above = 1'b0;
    alert_latch_mode_bit = 1'b0;
    for (int i = 0; i < 256; i++) regs[i] = 16'(rnd());
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    ctrl_u.hold(40);
    for (int a = 0; a < 8; a++) begin
      pins = 3'(a);
      p = 8'(rnd());
      ctrl_u.hold(20);
      ctrl_u.start();
      pins = ~pins;
      snd({4'h9, ~pins, 1'b0});
      chk(ack, 1'b1);
      snd(p);
      chk(ack, 1'b1);
      ctrl_u.stop();
      ctrl_u.hold(20);
      chk(reg_ptr, p);
      ctrl_u.start();
      snd({4'h9, ~pins, 1'b0});
      chk(ack, 1'b0);
      ctrl_u.stop();
    end
    $display("address test done");
    d = 16'(rnd());
    wrq.delete();
    wr(8'(rnd()), 2, d);
    ctrl_u.stop();
    ctrl_u.hold(20);
    chk(wrq.size(), 2);
    chk(wrq.pop_front(), {1'b1, d[15:8]});
    chk(wrq.pop_front(), {1'b0, d[7:0]});
    $display("write test done");
    p = 8'(rnd());
    e_rd = n_rd + 2;
    e_clr = n_clr + 1;
    wr(p, 0, 16'h0000);
    rd(w);
    chk(w, regs[p]);
    alert_active = 1'b1;
    alert_latch_mode_bit = 1'b1;
    rd(w);
    chk(w, regs[p]);
    alert_latch_mode_bit = 1'b0;
    alert_active = 1'b0;
    chk(n_rd, e_rd);
    chk(n_clr, e_clr);
    $display("read test done");
    ctrl_u.start();
    snd(8'h19);
    chk(ack, 1'b0);
    ctrl_u.stop();
    alert_active = 1'b1;
    for (int k = 0; k < 3; k++) begin
      alert_above = 1'(k);
      pins = k == 2 ? 3'h7 : 3'(rnd());
      e_clr += int'(k < 2);
      ctrl_u.hold(20);
      ctrl_u.start();
      snd(8'h19);
      chk(ack, 1'b1);
      // Third pass: a lower address on the wire wins arbitration
      ctrl_u.xfer(k == 2 ? 9'h121 : 9'h1ff, 9, rx);
      if (k < 2) chk(rx[8:1], {4'h9, pins, alert_above});
      ctrl_u.stop();
      ctrl_u.hold(20);
      chk(n_clr, e_clr);
    end
    alert_active = 1'b0;
    $display("alert response test done");
    for (int k = 0; k < 2; k++) begin
      ctrl_u.start();
      snd(8'h00);
      chk(ack, 1'b1);
      snd(k == 1 ? 8'h06 : 8'h04);
      chk(ack, 1'b1);
      ctrl_u.stop();
      ctrl_u.hold(20);
      chk(n_srst, k);
    end
    chk(reg_ptr, 8'h00);
    $display("general call test done");
    ctrl_u.start();
    snd({5'h01, 3'(rnd())});
    chk(ack, 1'b0);
    ctrl_u.hold(20);
    chk(hs_mode, 1'b1);
    wr(8'(rnd()), 0, 16'h0000);
    chk(hs_mode, 1'b1);
    ctrl_u.stop();
    ctrl_u.hold(20);
    chk(hs_mode, 1'b0);
    $display("hs test done");
    ctrl_u.start();
    ctrl_u.xfer({4'h9, pins, 1'b0, 1'b1}, 8, rx);
    ctrl_u.hold(30);
    chk(sda_oe_n, 1'b0);
    chk(sda_out, 1'b0);
    ctrl_u.hold(TOUT + 100);
    chk(sda_oe_n, 1'b1);
    ctrl_u.stop();
    p = 8'(rnd());
    wr(p, 0, 16'h0000);
    ctrl_u.stop();
    ctrl_u.hold(20);
    chk(reg_ptr, p);
    $display("timeout test done");
    final_report();
  end
endmodule
bind twowire_target twowire_checker #(.TOUT_CYCLES(TOUT_CYCLES)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .bus_clk(bus_clk), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_n(sda_oe_n), .reg_ptr(reg_ptr),
  .reg_wr_stb(reg_wr_stb), .reg_wr_hi(reg_wr_hi),
  .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb),
  .alert_latch_mode_bit(alert_latch_mode_bit),
  .alert_clear(alert_clear), .soft_reset(soft_reset), .hs_mode(hs_mode));

//--- verif/twowire_checker.sv
// Concurrent checks on the two-wire target port
`timescale 1ns/10ps
module twowire_checker #(
  parameter int unsigned TOUT_CYCLES = 200
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic [7:0] reg_ptr,
  input wire logic reg_wr_stb,
  input wire logic reg_wr_hi,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_stb,
  input wire logic alert_latch_mode_bit,
  input wire logic alert_clear,
  input wire logic soft_reset,
  input wire logic hs_mode
);
  logic sda_d_ff;
  logic hi_seen_ff;
  logic [7:0] stop_age_ff;
  logic [31:0] low_cnt_ff;
  // Length of the current SCL low and age of the last raw stop
  always_ff @(posedge ref_clk) begin
    sda_d_ff <= sda_in;
    if (rst || scl_in) low_cnt_ff <= 32'h0;
    else if (low_cnt_ff != 32'hffffffff) low_cnt_ff <= low_cnt_ff + 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) stop_age_ff <= 8'hff;
    else if (scl_in && sda_in && !sda_d_ff) stop_age_ff <= 8'h00;
    else if (stop_age_ff != 8'hff) stop_age_ff <= stop_age_ff + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) hi_seen_ff <= 1'b0;
    else if (reg_wr_stb) hi_seen_ff <= reg_wr_hi;
  end
  sequence s_rd_latched;
    reg_rd_stb && alert_latch_mode_bit;
  endsequence
  sequence s_clr_soon;
    ##[0:4] alert_clear;
  endsequence
  AST_WR_PULSE: assert property (
    @(posedge ref_clk) disable iff (rst) reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe wider than one cycle");
  AST_WR_DATA: assert property (
    @(posedge ref_clk) disable iff (rst)
    $changed(reg_wr_data) |-> reg_wr_stb)
    else $error("write data moved without a strobe");
  AST_LO_AFTER_HI: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_wr_stb && !reg_wr_hi |-> hi_seen_ff)
    else $error("low byte written before high byte");
  AST_LATCH_CLR: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_rd_latched |-> s_clr_soon or $past(alert_clear))
    else $error("latched read did not clear alert");
  AST_SRST_PTR: assert property (
    @(posedge ref_clk) disable iff (rst)
    soft_reset |-> ##[0:4] reg_ptr == 8'h00)
    else $error("pointer not cleared by reset command");
  AST_HS_STOP: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(hs_mode) |-> stop_age_ff < 8'h28)
    else $error("hs mode left without a stop");
  AST_TOUT: assert property (
    @(posedge ref_clk) disable iff (rst)
    low_cnt_ff >= TOUT_CYCLES + 50 |-> sda_oe_n)
    else $error("sda held after bus timeout");
  AST_SDA_STEADY: assert property (
    @(posedge bus_clk) disable iff (rst) scl_in [*4] |-> $stable(sda_oe_n))
    else $error("sda drive changed while scl high");
endmodule
